/* File: shared/vsll_params.svh */
// Constants of the serial latch loader: frame layout, reset values and timing counts.
`ifndef VSLL_PARAMS_SVH
`define VSLL_PARAMS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define VSLL_SEG_BITS      56
`define VSLL_DIM_BITS      10
`define VSLL_MODE_BITS     3
`define VSLL_FRAME_BITS    59
`define VSLL_STEP_BITS     10

// ****************************************************************
// Reset values
// ****************************************************************
`define VSLL_SHIFT_RST     59'h0
`define VSLL_SEG_RST       56'h0
`define VSLL_DIM_RST       10'h0
`define VSLL_CATH_RST      3'h6

// ****************************************************************
// Dimming and timebase
// ****************************************************************
`define VSLL_DIM_MAX       10'h3f8
`define VSLL_OSC_PER_BIT   4
`define VSLL_REF_MHZ       250
`define VSLL_FOSC_KHZ      3300
`define VSLL_OSC_DIV       ((`VSLL_REF_MHZ * 1000) / `VSLL_FOSC_KHZ)

`endif

/* File: shared/vsll_pkg.sv */
// Types shared by the serial latch loader modules.
`default_nettype none

package vsll_pkg;

    // Function mode, coded as {mode_bit_2, mode_bit_1, mode_bit_0}.
    typedef enum logic [2:0] {
        VSLL_FM_ALL = 3'h0,
        VSLL_FM_G1  = 3'h1,
        VSLL_FM_G2  = 3'h2,
        VSLL_FM_G3  = 3'h3,
        VSLL_FM_DIM = 3'h4
    } vsll_fmode_t;

    // Cathode phase, Gray coded along the multiplex cycle.
    typedef enum logic [1:0] {
        VSLL_PH_G1 = 2'h0,
        VSLL_PH_G2 = 2'h1,
        VSLL_PH_G3 = 2'h3
    } vsll_phase_t;

endpackage : vsll_pkg

`default_nettype wire

/* File: src/vsll_core.sv */
// Serial receive, latch loading and multiplex/dimming drive of the display driver.
// Contract
// - Power-on reset clears shift register and all segment and dimming latches.
// - Dimming duty is zero after reset, so nothing lights.
// - After reset all anode outputs are low and cathode one is low.
// - After reset cathode two and three outputs are high.
// - Bits shift only while select is high; host keeps transfers inside.
// - Serial data is sampled on each rising shift clock edge.
// - Select falling edge makes a load pulse copying payload into chosen latches.
// - Mode 000 all segments, 100/010/110 cathodes 1-3, 001 dimming.
// - Mode 0 writes one segment word into all three latches.
// - Modes 1 to 3 write only the selected cathode's latch.
// - Segment bit one drives its anode high in its phase.
// - One bit time equals four internal oscillator periods.
// - Anode on-time per phase is dimming value over 1024.
// - Segment frame is 56 bits, first anode first, then mode bits.
// - Dimming frame is ten bits LSB first, then mode bits.
// - Duty is limited to between 0/1024 and 1016/1024.
`timescale 1ns/1ps
`default_nettype none
`include "vsll_params.svh"

module vsll_core #(
    parameter int OSC_DIV = `VSLL_OSC_DIV
)(
    input  wire logic                      ref_clk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      cs_i,
    input  wire logic                      sclk_i,
    input  wire logic                      sdata_i,
    input  wire logic                      duty_select_input_i,
    output var  logic [`VSLL_SEG_BITS-1:0] anode_drive_outputs_o,
    output var  logic                      cathode_select_1_o,
    output var  logic                      cathode_select_2_o,
    output var  logic                      cathode_select_3_o
);
    localparam int FB = `VSLL_FRAME_BITS;
    localparam int SB = `VSLL_SEG_BITS;
    localparam int DB = `VSLL_DIM_BITS;
    localparam int OW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       sclk_d_q;
    logic       cs_d_q;
    wire        cs_s    = sync_q[0];
    wire        sclk_s  = sync_q[1];
    wire        sdata_s = sync_q[2];
    wire        duplex  = sync_q[3];
    wire        sclk_rise = sclk_s && !sclk_d_q;
    wire        cs_fall   = cs_d_q && !cs_s;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q   <= 4'h2;
            sync_q   <= 4'h2;
            sclk_d_q <= 1'b1;
            cs_d_q   <= 1'b0;
        end
        else
        begin
            meta_q   <= {duty_select_input_i, sdata_i, sclk_i, cs_i};
            sync_q   <= meta_q;
            sclk_d_q <= sclk_s;
            cs_d_q   <= cs_s;
        end
    end

    // ****************************************************************
    // Shift register and load request
    // ****************************************************************
    logic [FB-1:0] sh_q;
    logic          pend_q;
    wire           buf_in_ready;
    wire           buf_out_valid;
    wire  [FB-1:0] buf_data;
    logic          bit_tick;
    wire           shift_en = sclk_rise && cs_s && !pend_q;

    // The frame stays frozen while a load waits for buffer room, so a
    // slow latch writer never sees a half-shifted word.
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sh_q   <= `VSLL_SHIFT_RST;
            pend_q <= 1'b0;
        end
        else
        begin
            if (shift_en)
                sh_q <= {sh_q[FB-2:0], sdata_s};
            if (cs_fall)
                pend_q <= 1'b1;
            else if (buf_in_ready)
                pend_q <= 1'b0;
        end
    end

    vsll_fifo2 #(
        .WIDTH (FB),
        .DEPTH (2)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (pend_q),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (sh_q),
        .out_valid_o (buf_out_valid),
        .out_ready_i (bit_tick),
        .out_data_o  (buf_data)
    );

    // ****************************************************************
    // Frame decode
    // ****************************************************************
    // last three bits are mode bits 0, 1, 2
    function automatic vsll_pkg::vsll_fmode_t mode_of(input logic [FB-1:0] f);
        mode_of = vsll_pkg::vsll_fmode_t'({f[0], f[1], f[2]});
    endfunction : mode_of
    // first bit received lands on the first anode
    function automatic logic [SB-1:0] seg_of(input logic [FB-1:0] f);
        for (int i = 0; i < SB; i++)
            seg_of[i] = f[FB-1-i];
    endfunction : seg_of
    // LSB first, clamped to the top duty
    function automatic logic [DB-1:0] dim_of(input logic [FB-1:0] f);
        logic [DB-1:0] v;
        for (int i = 0; i < DB; i++)
            v[i] = f[`VSLL_MODE_BITS + DB - 1 - i];
        dim_of = (v > `VSLL_DIM_MAX) ? `VSLL_DIM_MAX : v;
    endfunction : dim_of

    wire                  apply  = buf_out_valid && bit_tick;
    vsll_pkg::vsll_fmode_t fmode;
    assign fmode = mode_of(buf_data);
    wire                  m_all  = (fmode == vsll_pkg::VSLL_FM_ALL);
    wire [2:0]            wr_seg = {3{apply}} & {
        m_all || (fmode == vsll_pkg::VSLL_FM_G3),
        m_all || (fmode == vsll_pkg::VSLL_FM_G2),
        m_all || (fmode == vsll_pkg::VSLL_FM_G1)};
    wire                  wr_dim = apply && (fmode == vsll_pkg::VSLL_FM_DIM);

    // ****************************************************************
    // Latches
    // ****************************************************************
    logic [SB-1:0] lat_q [3];
    logic [DB-1:0] dim_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int k = 0; k < 3; k++)
                lat_q[k] <= `VSLL_SEG_RST;
            dim_q    <= `VSLL_DIM_RST;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
                if (wr_seg[k])
                    lat_q[k] <= seg_of(buf_data);
            if (wr_dim)
                dim_q <= dim_of(buf_data);
        end
    end

    // ****************************************************************
    // Timebase and multiplex
    // ****************************************************************
    logic [OW-1:0]            osc_q;
    logic [1:0]               quad_q;
    logic [`VSLL_STEP_BITS-1:0] step_q;
    vsll_pkg::vsll_phase_t    ph_q;
    vsll_pkg::vsll_phase_t    ph_d;
    wire                      osc_tick = (osc_q == OW'(OSC_DIV - 1));
    wire                      ph_end   = bit_tick && (step_q == '1);

    // bit time is four oscillator periods
    assign bit_tick = osc_tick && (quad_q == 2'(`VSLL_OSC_PER_BIT - 1));
    // two or three phases per duty select
    always_comb
    begin
        case (ph_q)
            vsll_pkg::VSLL_PH_G1: ph_d = vsll_pkg::VSLL_PH_G2;
            vsll_pkg::VSLL_PH_G2: ph_d = duplex ? vsll_pkg::VSLL_PH_G1 : vsll_pkg::VSLL_PH_G3;
            vsll_pkg::VSLL_PH_G3: ph_d = vsll_pkg::VSLL_PH_G1;
            default:              ph_d = vsll_pkg::VSLL_PH_G1;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            osc_q  <= '0;
            quad_q <= 2'h0;
            step_q <= '0;
            ph_q   <= vsll_pkg::VSLL_PH_G1;
        end
        else
        begin
            osc_q <= osc_tick ? '0 : OW'(osc_q + 1'b1);
            if (osc_tick)
                quad_q <= quad_q + 2'h1;
            if (bit_tick)
                step_q <= step_q + 1'b1;
            if (ph_end)
                ph_q <= ph_d;
        end
    end

    wire [1:0] lat_idx = (ph_q == vsll_pkg::VSLL_PH_G1) ? 2'h0 :
                         (ph_q == vsll_pkg::VSLL_PH_G2) ? 2'h1 : 2'h2;
    // lit for the first dim_q steps of each phase
    wire       lit_win = (step_q < dim_q);
    // a one drives the anode high
    wire [SB-1:0] anode_d = lat_q[lat_idx] & {SB{lit_win}};
    wire [2:0]    cath_d  = ~(3'h1 << lat_idx);
    logic [SB-1:0] anode_q;
    logic [2:0]    cath_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            anode_q <= `VSLL_SEG_RST;
            cath_q  <= `VSLL_CATH_RST;
        end
        else
        begin
            anode_q <= anode_d;
            cath_q  <= cath_d;
        end
    end

    assign anode_drive_outputs_o = anode_q;
    assign cathode_select_1_o    = cath_q[0];
    assign cathode_select_2_o    = cath_q[1];
    assign cathode_select_3_o    = cath_q[2];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_shift_edge;
        shift_en;
    endsequence
    sequence s_select_fall;
        cs_d_q && !cs_s;
    endsequence
    sequence s_dark_two;
        (dim_q == '0) [*2];
    endsequence

    a_shift_sample: assert property (s_shift_edge |=> sh_q[0] == $past(sdata_s))
        else $error("shift register missed a sampled bit");
    a_shift_idle: assert property (!cs_s && !pend_q |=> sh_q == $past(sh_q))
        else $error("shift register moved while deselected");
    a_load_pulse: assert property (s_select_fall |=> pend_q)
        else $error("no load request after select fall");
    a_mode_all: assert property (apply && m_all |=>
        lat_q[0] == lat_q[1] && lat_q[1] == lat_q[2] && lat_q[0] == $past(seg_of(buf_data)))
        else $error("mode 0 did not fill all latches");
    a_mode_one: assert property (apply && fmode == vsll_pkg::VSLL_FM_G2 |=>
        lat_q[0] == $past(lat_q[0]) && lat_q[2] == $past(lat_q[2]))
        else $error("single-phase write touched another latch");
    a_bad_mode: assert property (apply && !(|wr_seg) && !wr_dim |=>
        lat_q[0] == $past(lat_q[0]) && lat_q[1] == $past(lat_q[1])
        && lat_q[2] == $past(lat_q[2]) && dim_q == $past(dim_q))
        else $error("undefined mode changed a latch");
    a_dim_limit: assert property (dim_q <= `VSLL_DIM_MAX)
        else $error("dimming value above limit");
    a_dark_anode: assert property (s_dark_two |-> anode_q == '0)
        else $error("anode lit with zero dimming");
    a_bit_time: assert property (bit_tick |-> osc_tick && quad_q == 2'h3)
        else $error("bit tick not on fourth oscillator period");
    a_one_cathode: assert property ($countones(~cath_q) == 1)
        else $error("not exactly one cathode active");
    a_duplex_skip: assert property (ph_end && duplex && ph_q == vsll_pkg::VSLL_PH_G2
        |=> ph_q == vsll_pkg::VSLL_PH_G1)
        else $error("duplex cycle entered third phase");

endmodule : vsll_core

`default_nettype wire

/* File: src/vsll_fifo2.sv */
// Small valid/ready buffer between the frame loader and the latch writer.
`timescale 1ns/1ps
`default_nettype none

module vsll_fifo2 #(
    parameter int WIDTH = 59,
    parameter int DEPTH = 2
)(
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i,
    output var  logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    wire              push;
    wire              pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : next_ptr

    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_i;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= next_ptr(wr_ptr_q);
            if (pop)
                rd_ptr_q <= next_ptr(rd_ptr_q);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : vsll_fifo2

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the serial latch loader driven by the host model.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int OSC_DIV = 2;
    localparam int STEP    = 4 * OSC_DIV;

    typedef struct {
        int          k;
        logic [55:0] val;
        int          d;
    } vsll_note_t;

    logic             ref_clk_i = 1'b0;
    logic             rstn_i    = 1'b0;
    logic             duty      = 1'b0;
    logic             mon_busy  = 1'b0;
    wire  logic       cs;
    wire  logic       sclk;
    wire  logic       sdata;
    wire  logic [55:0] anodes;
    wire  logic [2:0] cath;
    int               fails     = 0;
    int               n_checks  = 0;
    int               seed      = 89514;
    vsll_note_t       notes[$];
    logic [55:0]      pat[5];

    always #2 ref_clk_i = ~ref_clk_i;

    vsll_host_model host (
        .ref_clk_i (ref_clk_i),
        .cs_o      (cs),
        .sclk_o    (sclk),
        .sdata_o   (sdata)
    );

    vsll_core #(.OSC_DIV(OSC_DIV)) DUT (
        .ref_clk_i             (ref_clk_i),
        .rstn_i                (rstn_i),
        .cs_i                  (cs),
        .sclk_i                (sclk),
        .sdata_i               (sdata),
        .duty_select_input_i   (duty),
        .anode_drive_outputs_o (anodes),
        .cathode_select_1_o    (cath[0]),
        .cathode_select_2_o    (cath[1]),
        .cathode_select_3_o    (cath[2])
    );

    // ********************************
    // Checking and verdict
    // ********************************
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic at_step(input int s, inout int t);
        repeat (s * STEP + 4 - t) @(negedge ref_clk_i);
        t = (s * STEP + 4 > t) ? s * STEP + 4 : t;
    endtask : at_step

    task automatic push(input int k, input logic [55:0] v, input int d);
        vsll_note_t nt;
        nt.k   = k;
        nt.val = v;
        nt.d   = d;
        notes.push_back(nt);
    endtask : push

    task automatic drain;
        repeat (40) @(negedge ref_clk_i);
        wait (notes.size() == 0 && !mon_busy);
        @(negedge ref_clk_i);
    endtask : drain

    // Each note is checked inside the next phase of its cathode, sampled
    // mid-step so a one-cycle skew of the registered outputs cannot matter.
    always
    begin : monitor
        vsll_note_t nt;
        int         t;
        wait (notes.size() > 0);
        mon_busy = 1'b1;
        nt = notes.pop_front();
        wait (cath[nt.k] === 1'b1);
        wait (cath[nt.k] === 1'b0);
        t = 0;
        at_step(2, t);
        check({53'h0, cath}, {53'h0, ~(3'h1 << nt.k)});
        check(anodes, (nt.d > 2) ? nt.val : 56'h0);
        if (nt.d > 0)
        begin
            at_step(nt.d - 1, t);
            check(anodes, nt.val);
        end
        at_step(nt.d, t);
        check(anodes, 56'h0);
        mon_busy = 1'b0;
    end

    initial
    begin : watchdog
        // Twelve display phases outlast every scenario; a hang ends here as a failure.
        repeat (12 * 1024 * STEP) @(posedge ref_clk_i);
        fails++;
        finish_test();
    end

    // ********************************
    // Scenarios
    // ********************************
    initial
    begin : main
        for (int i = 0; i < 5; i++)
            pat[i] = 56'({$random(seed), $random(seed)});
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        check(anodes, 56'h0);
        check({53'h0, cath}, 56'h6);
        host.send_seg(pat[0], vsll_pkg::VSLL_FM_ALL, 1'b1, 8);
        drain();
        // Notes follow the multiplex order, so each one waits at most one phase.
        push(1, pat[0], 0);
        drain();
        host.send_dim(10'h3ff, vsll_pkg::VSLL_FM_DIM, 8);
        drain();
        push(2, pat[0], 1016);
        push(0, pat[0], 1016);
        push(1, pat[0], 1016);
        drain();
        // Back-to-back frames lean on the two-entry buffer; one is slowed.
        host.send_seg(pat[1], vsll_pkg::VSLL_FM_G1, 1'b1, 8);
        host.send_seg(pat[2], vsll_pkg::VSLL_FM_G2, 1'b1, 20);
        host.send_seg(pat[3], vsll_pkg::VSLL_FM_G3, 1'b1, 8);
        host.send_seg(pat[4], 3'h5, 1'b1, 8);
        host.send_seg(pat[4], vsll_pkg::VSLL_FM_ALL, 1'b0, 8);
        host.send_dim(10'h040, vsll_pkg::VSLL_FM_DIM, 8);
        drain();
        push(0, pat[1], 64);
        push(1, pat[2], 64);
        push(2, pat[3], 64);
        drain();
        duty = 1'b1;
        push(0, pat[1], 64);
        push(1, pat[2], 64);
        drain();
        finish_test();
    end
endmodule : testbench

`default_nettype wire

/* File: tb/vsll_host_model.sv */
// Host model that drives the three-wire serial link of the latch loader.
`timescale 1ns/1ps
`default_nettype none

module vsll_host_model (
    input  wire logic ref_clk_i,
    output var  logic cs_o,
    output var  logic sclk_o,
    output var  logic sdata_o
);
    // ********************************
    // Link idle state and bit timing
    // ********************************
    // Shift clock idles high.
    initial
    begin
        cs_o    = 1'b0;
        sclk_o  = 1'b1;
        sdata_o = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wait_cyc

    // Data changes with the falling edge, stable at the rise.
    task automatic put_bit(input logic b, input int half);
        sclk_o  = 1'b0;
        sdata_o = b;
        wait_cyc(half);
        sclk_o = 1'b1;
        wait_cyc(half);
    endtask : put_bit

    // Bits stay inside the select window when sel is set.
    task automatic open_frame(input logic sel, input int half);
        cs_o = sel;
        wait_cyc(half);
    endtask : open_frame

    // Mode bits go last, bit 0 first.
    task automatic close_frame(input logic [2:0] mode, input int half);
        for (int i = 0; i < 3; i++)
            put_bit(mode[i], half);
        cs_o = 1'b0;
        // A released line must not keep showing the last bit.
        sdata_o = ~sdata_o;
        wait_cyc(half);
    endtask : close_frame

    // First segment bit goes out first.
    task automatic send_seg(input logic [55:0] pay, input logic [2:0] mode,
                            input logic sel, input int half);
        open_frame(sel, half);
        for (int i = 0; i < 56; i++)
            put_bit(pay[i], half);
        close_frame(mode, half);
    endtask : send_seg

    // Dimming value goes out LSB first.
    task automatic send_dim(input logic [9:0] dim, input logic [2:0] mode, input int half);
        open_frame(1'b1, half);
        for (int i = 0; i < 10; i++)
            put_bit(dim[i], half);
        close_frame(mode, half);
    endtask : send_dim
endmodule : vsll_host_model

`default_nettype wire
